// ---- rtl/cnt_pkg.sv ----
// constants and types for the channel tuner (crossbar, oscillator, mixer)
// assumes one sample clock per channel; register writes arrive as strobes
package cnt_pkg;
  localparam int unsigned CNT_FREQ_W = 32;
  localparam int unsigned CNT_PHASE_W = 20;
  localparam int unsigned CNT_OFFSET_W = 16;
  localparam int unsigned CNT_LUT_ADDR_W = 18;
  localparam int unsigned CNT_AMP_W = 17;
  localparam int unsigned CNT_HOLD_W = 16;
  localparam int unsigned CNT_MAG_W = 16;
  localparam int unsigned CNT_EXP_W = 3;
  localparam int unsigned CNT_PDITH_W = 4;
  localparam int unsigned CNT_ADITH_W = 2;
  localparam logic [31:0] CNT_FREQ_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_HOLD_RST = 16'h0001;
  localparam logic [15:0] CNT_OFFSET_RST = 16'h0000;
  localparam logic [22:0] CNT_LFSR_SEED = 23'h000001;
  localparam logic [2:0] CNT_SEL_A = 3'h0;
  localparam logic [2:0] CNT_SEL_B = 3'h1;
  localparam logic [2:0] CNT_SEL_C = 3'h2;
  localparam logic [2:0] CNT_SEL_D = 3'h3;
  localparam logic [2:0] CNT_SEL_PN_REAL = 3'h4;
  localparam logic [2:0] CNT_SEL_AB = 3'h0;
  localparam logic [2:0] CNT_SEL_CD = 3'h1;
  localparam logic [2:0] CNT_SEL_PN_CPLX = 3'h2;

  // hold-off sequencer: idle -> counting -> idle (gray along the path)
  typedef enum logic [1:0] {
    CNT_ST_IDLE = 2'b00,
    CNT_ST_COUNT = 2'b01
  } cnt_hold_st_t;
endpackage : cnt_pkg

// ---- rtl/cnt_sincos.sv ----
// quadrature oscillator output stage: phase word to cosine and sine
// assumes the caller supplies an 18-bit phase; the result is registered here on ce
`timescale 1ns/1ps
`default_nettype none
module cnt_sincos
  import cnt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [17:0] phase,
  output logic signed [16:0] cos_out,
  output logic signed [16:0] sin_out
);
  // half-wave parabola approximation; spur level is traded for area,
  // a full table would need 2^18 words per channel
  function automatic logic signed [16:0] half_wave(input logic [16:0] p);
    logic [33:0] sq;
    logic [16:0] x;
    sq = 34'h0;
    x = p;
    sq = 34'(x) * 34'(18'h20000 - 18'(x));
    return 17'(sq[32:17]);
  endfunction : half_wave

  // cosine is the sine a quarter turn ahead; the peak is exactly 2^15
  wire logic [17:0] cos_ph = phase + 18'h10000;
  wire logic cos_neg = cos_ph[17];
  wire logic signed [16:0] sin_mag = half_wave(phase[16:0]);
  wire logic signed [16:0] cos_mag = half_wave(cos_ph[16:0]);
  wire logic signed [16:0] sin_v = phase[17] ? -sin_mag : sin_mag;
  wire logic signed [16:0] cos_v = cos_neg ? -cos_mag : cos_mag;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cos_out <= 17'h0;
      sin_out <= 17'h0;
    end
    else if (ce)
    begin
      cos_out <= cos_v;
      sin_out <= sin_v;
    end
endmodule : cnt_sincos
`default_nettype wire

// ---- rtl/cnt_tuner.sv ----
// channel tuner: input crossbar, phase accumulator oscillator and mixer
// assumes all ports are synchronous to clk, the selected port's sample clock
// Functional notes
// - tuning word is signed: 0x80000000 is -fs/2, 0x7fffffff just under +fs/2
// - real mode selects 000..011 route port a, b, c or d
// - pseudorandom source on 100 real or 010 complex
// - complex 000: a is in-phase, b quadrature, a's exponent used
// - complex 001: c is in-phase, d quadrature, c's exponent used
// - mixer uses two products for real, four for complex input
// - bypass skips oscillator and mixer, passing i and q straight through
// - clear bit zeroes the accumulator at each hop, offset still applied
// - clear bit low keeps accumulator phase across a hop
// - phase dither adds random bits into accumulator low bits
// - amplitude dither adds random bits to cosine and subtracts them from sine low bits
// - host frequency writes land in a shadow register
// - sync loads 16-bit hold-off counter, decremented per sample clock
// - counter reaching zero copies shadow into active frequency
// - hold-off of one updates at the sync itself
// - 16-bit unsigned phase offset added to accumulator phase
// - 20-bit phase plus offset, 18 bits to sine/cosine, 17-bit amplitude
// - each channel has a 3-bit source select and complex flag
`timescale 1ns/1ps
`default_nettype none
module cnt_tuner
  import cnt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [15:0] port_a_mag,
  input wire logic [2:0] port_a_exp,
  input wire logic [15:0] port_b_mag,
  input wire logic [2:0] port_b_exp,
  input wire logic [15:0] port_c_mag,
  input wire logic [2:0] port_c_exp,
  input wire logic [15:0] port_d_mag,
  input wire logic [2:0] port_d_exp,
  input wire logic [2:0] src_sel,
  input wire logic cplx_in,
  input wire logic osc_bypass,
  input wire logic clr_acc_on_hop,
  input wire logic phase_dither_en,
  input wire logic amp_dither_en,
  input wire logic freq_wr,
  input wire logic [31:0] freq_wdata,
  input wire logic hold_wr,
  input wire logic [15:0] hold_wdata,
  input wire logic offset_wr,
  input wire logic [15:0] offset_wdata,
  input wire logic start_sync,
  input wire logic hop_sync,
  output logic signed [17:0] out_i,
  output logic signed [17:0] out_q,
  output logic [2:0] out_exp,
  output logic out_src_valid,
  output logic [31:0] carrier_tuning_word,
  output logic [31:0] freq_shadow,
  output logic [15:0] hold_count,
  output logic hold_busy
);
  logic [31:0] shadow_ff;
  logic [31:0] active_ff;
  logic [15:0] hold_ff;
  logic [15:0] offset_ff;
  logic [15:0] cnt_ff;
  cnt_hold_st_t st_ff;
  logic [31:0] acc_ff;
  logic [22:0] lfsr_ff;
  logic [15:0] pn_i_ff;
  logic [15:0] pn_q_ff;
  logic signed [16:0] cos_w;
  logic signed [16:0] sin_w;

  function automatic logic [15:0] eff_hold(input logic [15:0] v);
    return (v == 16'h0) ? 16'h1 : v;
  endfunction : eff_hold

  // truncated, saturation-free scaling of a 16x17 product back to 18 bits
  function automatic logic signed [17:0] mul_s(input logic signed [15:0] a, input logic signed [16:0] b);
    logic signed [32:0] p;
    p = 33'sh0;
    p = 33'(a) * 33'(b);
    return 18'(p[32:15]);
  endfunction : mul_s

  // ---------------- input crossbar ----------------
  wire logic sel_pn = (!cplx_in && src_sel == CNT_SEL_PN_REAL) ||
                      (cplx_in && src_sel == CNT_SEL_PN_CPLX);
  wire logic sel_ab = cplx_in && src_sel == CNT_SEL_AB;
  wire logic sel_cd = cplx_in && src_sel == CNT_SEL_CD;
  wire logic is_cplx = sel_ab || sel_cd || (cplx_in && sel_pn);
  // unused select codes give zero data and drop out_src_valid
  wire logic sel_ok = sel_pn || sel_ab || sel_cd || (!cplx_in && src_sel <= CNT_SEL_D);
  logic [15:0] x_i;
  logic [15:0] x_q;
  logic [2:0] x_exp;
  always_comb
  begin
    x_i = 16'h0;
    x_q = 16'h0;
    x_exp = 3'h0;
    if (sel_pn)
    begin
      x_i = pn_i_ff;
      x_q = cplx_in ? pn_q_ff : 16'h0;
      x_exp = lfsr_ff[2:0];
    end
    else if (sel_ab)
    begin
      x_i = port_a_mag;
      x_q = port_b_mag;
      x_exp = port_a_exp;
    end
    else if (sel_cd)
    begin
      x_i = port_c_mag;
      x_q = port_d_mag;
      x_exp = port_c_exp;
    end
    else if (!cplx_in)
    begin
      case (src_sel)
        CNT_SEL_A:
        begin
          x_i = port_a_mag;
          x_exp = port_a_exp;
        end
        CNT_SEL_B:
        begin
          x_i = port_b_mag;
          x_exp = port_b_exp;
        end
        CNT_SEL_C:
        begin
          x_i = port_c_mag;
          x_exp = port_c_exp;
        end
        CNT_SEL_D:
        begin
          x_i = port_d_mag;
          x_exp = port_d_exp;
        end
        default:
        begin
          x_i = 16'h0;
          x_exp = 3'h0;
        end
      endcase
    end
  end

  // ---------------- frequency shadow and hold-off ----------------
  wire logic sync = start_sync || hop_sync;
  wire logic [15:0] load_val = eff_hold(hold_ff);
  wire logic hop_now = (sync && load_val == 16'h1) ||
                       (st_ff == CNT_ST_COUNT && !sync && cnt_ff == 16'h1);
  // a sync that arrives while counting reloads the counter, so only the
  // latest sync's hold-off is honoured
  wire logic [15:0] nxt_cnt = sync ? load_val - 16'h1 :
                              (st_ff == CNT_ST_COUNT ? cnt_ff - 16'h1 : cnt_ff);
  cnt_hold_st_t nxt_st;
  always_comb
  begin
    case (st_ff)
      CNT_ST_IDLE: nxt_st = (sync && !hop_now) ? CNT_ST_COUNT : CNT_ST_IDLE;
      CNT_ST_COUNT: nxt_st = (hop_now && !sync) ? CNT_ST_IDLE : CNT_ST_COUNT;
      default: nxt_st = CNT_ST_IDLE;
    endcase
    if (sync && hop_now)
      nxt_st = CNT_ST_IDLE;
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      shadow_ff <= CNT_FREQ_RST;
      hold_ff <= CNT_HOLD_RST;
      offset_ff <= CNT_OFFSET_RST;
    end
    else if (ce)
    begin
      if (freq_wr)
        shadow_ff <= freq_wdata;
      if (hold_wr)
        hold_ff <= hold_wdata;
      if (offset_wr)
        offset_ff <= offset_wdata;
    end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      st_ff <= CNT_ST_IDLE;
      cnt_ff <= 16'h0;
      active_ff <= CNT_FREQ_RST;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      if (hop_now)
        active_ff <= shadow_ff;
    end

  // ---------------- phase accumulator and dither ----------------
  wire logic [31:0] pdither = phase_dither_en ? {28'h0, lfsr_ff[CNT_PDITH_W-1:0]} : 32'h0;
  wire logic [31:0] acc_base = (hop_now && clr_acc_on_hop) ? 32'h0 : acc_ff;
  // signed word added modulo 2^32 covers both tuning directions
  wire logic [31:0] nxt_acc = acc_base + active_ff + pdither;
  wire logic [19:0] phase20 = acc_ff[31:12];
  wire logic [19:0] phase_off = phase20 + {offset_ff, 4'h0};
  wire logic [17:0] lut_phase = phase_off[19:2];

  // one shared sequence feeds both dithers and the test source; the
  // correlation between them is accepted to save a second generator
  wire logic [22:0] nxt_lfsr = {lfsr_ff[21:0], lfsr_ff[22] ^ lfsr_ff[17]};

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      acc_ff <= 32'h0;
    else if (ce)
      acc_ff <= nxt_acc;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      lfsr_ff <= CNT_LFSR_SEED;
      pn_i_ff <= 16'h0;
      pn_q_ff <= 16'h0;
    end
    else if (ce)
    begin
      lfsr_ff <= nxt_lfsr;
      pn_i_ff <= lfsr_ff[15:0];
      pn_q_ff <= lfsr_ff[22:7];
    end

  cnt_sincos u_sincos (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .phase(lut_phase),
    .cos_out(cos_w),
    .sin_out(sin_w)
  );

  wire logic signed [16:0] adith = amp_dither_en ? 17'(signed'({1'b0, lfsr_ff[20:19]})) : 17'sh0;
  wire logic signed [16:0] cos_d = cos_w + adith;
  wire logic signed [16:0] sin_d = sin_w - adith;

  // ---------------- mixer ----------------
  // x * exp(-jw): i = xi*cos + xq*sin, q = xq*cos - xi*sin
  wire logic signed [17:0] p_ic = mul_s(x_i, cos_d);
  wire logic signed [17:0] p_is = mul_s(x_i, sin_d);
  wire logic signed [17:0] p_qc = is_cplx ? mul_s(x_q, cos_d) : 18'sh0;
  wire logic signed [17:0] p_qs = is_cplx ? mul_s(x_q, sin_d) : 18'sh0;
  wire logic signed [17:0] mix_i = p_ic + p_qs;
  wire logic signed [17:0] mix_q = p_qc - p_is;
  // bypass keeps full input resolution, sign-extended into the 18-bit path
  wire logic signed [17:0] nxt_i = osc_bypass ? {{2{x_i[15]}}, x_i} : mix_i;
  wire logic signed [17:0] nxt_q = osc_bypass ? {{2{x_q[15]}}, x_q} : mix_q;

  wire logic [31:0] nxt_ctw = hop_now ? shadow_ff : active_ff;
  wire logic [31:0] nxt_shadow_out = freq_wr ? freq_wdata : shadow_ff;
  wire logic nxt_busy = (nxt_st == CNT_ST_COUNT);

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      out_i <= 18'h0;
      out_q <= 18'h0;
      out_exp <= 3'h0;
      out_src_valid <= 1'b0;
    end
    else if (ce)
    begin
      out_i <= nxt_i;
      out_q <= nxt_q;
      out_exp <= x_exp;
      out_src_valid <= sel_ok;
    end

  // status copies follow the registers' next values so they never lag them
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      carrier_tuning_word <= CNT_FREQ_RST;
      freq_shadow <= CNT_FREQ_RST;
      hold_count <= 16'h0;
      hold_busy <= 1'b0;
    end
    else if (ce)
    begin
      carrier_tuning_word <= nxt_ctw;
      freq_shadow <= nxt_shadow_out;
      hold_count <= nxt_cnt;
      hold_busy <= nxt_busy;
    end
endmodule : cnt_tuner
`default_nettype wire

// ---- tb/cnt_tuner_chk.sv ----
// checker for the channel tuner: hold-off transfer, shadow write and crossbar
// assumes it is bound to cnt_tuner and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module cnt_tuner_chk
  import cnt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [15:0] port_a_mag,
  input wire logic [2:0] port_a_exp,
  input wire logic [2:0] src_sel,
  input wire logic cplx_in,
  input wire logic osc_bypass,
  input wire logic freq_wr,
  input wire logic [31:0] freq_wdata,
  input wire logic hold_wr,
  input wire logic [15:0] hold_wdata,
  input wire logic start_sync,
  input wire logic hop_sync,
  input wire logic signed [17:0] out_i,
  input wire logic [2:0] out_exp,
  input wire logic out_src_valid,
  input wire logic [31:0] carrier_tuning_word,
  input wire logic [31:0] freq_shadow,
  input wire logic [15:0] hold_count,
  input wire logic hold_busy
);
  logic [15:0] hold_v_ff;
  wire sync = ce && (start_sync || hop_sync);
  wire legal = !cplx_in && src_sel < 3'h5 || cplx_in && src_sel < 3'h3;
  // mirror of the hold-off register, so load values can be predicted
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      hold_v_ff <= CNT_HOLD_RST;
    else if (ce && hold_wr)
      hold_v_ff <= hold_wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_shadow_write: assert property (ce && freq_wr |=> freq_shadow == $past(freq_wdata))
    else $error("shadow missed write");
  a_active_held: assert property (ce && !sync && !hold_busy |=> $stable(carrier_tuning_word))
    else $error("active word moved without transfer");
  a_hold_one: assert property (sync && hold_v_ff < 16'h0002 |=> !hold_busy && carrier_tuning_word == $past(freq_shadow))
    else $error("short hold-off not immediate");
  a_hold_load: assert property (sync && hold_v_ff > 16'h0001 |=> hold_busy && hold_count == $past(hold_v_ff) - 16'h0001)
    else $error("hold-off load wrong");
  a_count_down: assert property (ce && hold_busy && !sync |=> hold_count == $past(hold_count) - 16'h0001)
    else $error("count did not step");
  a_zero_copy: assert property (ce && hold_busy && !sync && hold_count == 16'h0001
    |=> !hold_busy && carrier_tuning_word == $past(freq_shadow))
    else $error("transfer at zero missed");
  a_real_port_a: assert property (ce && osc_bypass && !cplx_in && src_sel == 3'h0
    |=> out_i == $signed($past(port_a_mag)) && out_exp == $past(port_a_exp))
    else $error("port a bypass path wrong");
  a_src_valid: assert property (ce |=> out_src_valid == $past(legal))
    else $error("source valid wrong");
endmodule : cnt_tuner_chk
bind cnt_tuner cnt_tuner_chk chk_u (
  .clk(clk),
  .rst_n(rst_n),
  .ce(ce),
  .port_a_mag(port_a_mag),
  .port_a_exp(port_a_exp),
  .src_sel(src_sel),
  .cplx_in(cplx_in),
  .osc_bypass(osc_bypass),
  .freq_wr(freq_wr),
  .freq_wdata(freq_wdata),
  .hold_wr(hold_wr),
  .hold_wdata(hold_wdata),
  .start_sync(start_sync),
  .hop_sync(hop_sync),
  .out_i(out_i),
  .out_exp(out_exp),
  .out_src_valid(out_src_valid),
  .carrier_tuning_word(carrier_tuning_word),
  .freq_shadow(freq_shadow),
  .hold_count(hold_count),
  .hold_busy(hold_busy)
);
`default_nettype wire

// ---- tb/cnt_adc_model.sv ----
// converter port model: four sample ports with fresh values every cycle
// assumes samples change on the falling edge of the port clock
`timescale 1ns/1ps
`default_nettype none
module cnt_adc_model
(
  input wire logic clk,
  output logic [15:0] port_a_mag,
  output logic [2:0] port_a_exp,
  output logic [15:0] port_b_mag,
  output logic [2:0] port_b_exp,
  output logic [15:0] port_c_mag,
  output logic [2:0] port_c_exp,
  output logic [15:0] port_d_mag,
  output logic [2:0] port_d_exp
);
  // new data every cycle, so a stale sample can never pass for a match
  initial
  begin
    {port_a_mag, port_a_exp, port_b_mag, port_b_exp} = 38'h0;
    {port_c_mag, port_c_exp, port_d_mag, port_d_exp} = 38'h0;
    forever
    begin
      @(negedge clk);
      {port_a_mag, port_a_exp} = 19'($urandom);
      {port_b_mag, port_b_exp} = 19'($urandom);
      {port_c_mag, port_c_exp} = 19'($urandom);
      {port_d_mag, port_d_exp} = 19'($urandom);
    end
  end
endmodule : cnt_adc_model
`default_nettype wire

// ---- tb/cnt_tuner_tb.sv ----
// bench: crossbar table in bypass and through the mixer, hold-off transfers, freeze
// assumes the package, the design and the port model are compiled first
`timescale 1ns/1ps
`default_nettype none
module cnt_tuner_tb;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, cplx_in = 1'b0, osc_bypass = 1'b1;
  logic clr_acc_on_hop = 1'b0, phase_dither_en = 1'b0, amp_dither_en = 1'b0;
  logic freq_wr = 1'b0, hold_wr = 1'b0, offset_wr = 1'b0, start_sync = 1'b0, hop_sync = 1'b0;
  logic [2:0] src_sel = 3'h0;
  logic [31:0] freq_wdata = 32'h0, model_act = 32'h0;
  logic [15:0] hold_wdata = 16'h0, offset_wdata = 16'h0;
  logic signed [17:0] held_i = 18'sh0;
  wire logic [15:0] port_a_mag, port_b_mag, port_c_mag, port_d_mag, hold_count;
  wire logic [2:0] port_a_exp, port_b_exp, port_c_exp, port_d_exp, out_exp;
  wire logic signed [17:0] out_i, out_q;
  wire logic out_src_valid, hold_busy;
  wire logic [31:0] carrier_tuning_word, freq_shadow;
  int err_total = 0, samples_checked = 0, cyc = 0;
  cnt_adc_model src_u (
    .clk(clk),
    .port_a_mag(port_a_mag),
    .port_a_exp(port_a_exp),
    .port_b_mag(port_b_mag),
    .port_b_exp(port_b_exp),
    .port_c_mag(port_c_mag),
    .port_c_exp(port_c_exp),
    .port_d_mag(port_d_mag),
    .port_d_exp(port_d_exp)
  );
  cnt_tuner dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .port_a_mag(port_a_mag),
    .port_a_exp(port_a_exp),
    .port_b_mag(port_b_mag),
    .port_b_exp(port_b_exp),
    .port_c_mag(port_c_mag),
    .port_c_exp(port_c_exp),
    .port_d_mag(port_d_mag),
    .port_d_exp(port_d_exp),
    .src_sel(src_sel),
    .cplx_in(cplx_in),
    .osc_bypass(osc_bypass),
    .clr_acc_on_hop(clr_acc_on_hop),
    .phase_dither_en(phase_dither_en),
    .amp_dither_en(amp_dither_en),
    .freq_wr(freq_wr),
    .freq_wdata(freq_wdata),
    .hold_wr(hold_wr),
    .hold_wdata(hold_wdata),
    .offset_wr(offset_wr),
    .offset_wdata(offset_wdata),
    .start_sync(start_sync),
    .hop_sync(hop_sync),
    .out_i(out_i),
    .out_q(out_q),
    .out_exp(out_exp),
    .out_src_valid(out_src_valid),
    .carrier_tuning_word(carrier_tuning_word),
    .freq_shadow(freq_shadow),
    .hold_count(hold_count),
    .hold_busy(hold_busy)
  );
  initial
    forever #50 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic xbar(input int k);
    logic [15:0] mi;
    logic [2:0] me;
    case (k)
      0, 8: {mi, me} = {port_a_mag, port_a_exp};
      1: {mi, me} = {port_b_mag, port_b_exp};
      2, 9: {mi, me} = {port_c_mag, port_c_exp};
      3: {mi, me} = {port_d_mag, port_d_exp};
      default: {mi, me} = 19'h0;
    endcase
    chk(32'(out_src_valid), 32'(k < 5 || k > 7 && k < 11));
    if (k != 4 && k != 10)
      chk(32'(out_i), 32'($signed(mi)));
    if (k < 4 || k == 8 || k == 9)
      chk(32'(out_exp), 32'(me));
    if (k == 8 || k == 9)
      chk(32'(out_q), 32'($signed(k == 8 ? port_b_mag : port_d_mag)));
    if (k < 4)
      chk(32'(out_q), 32'h0);
  endtask : xbar
  task automatic hop(input logic [15:0] h, input logic st);
    int n;
    n = h < 2 ? 1 : int'(h);
    @(negedge clk);
    {hold_wr, hold_wdata, freq_wr, freq_wdata} = {1'b1, h, 1'b1, 32'($urandom)};
    @(negedge clk);
    {hold_wr, freq_wr} = 2'b00;
    chk(freq_shadow, freq_wdata);
    chk(carrier_tuning_word, model_act);
    {start_sync, hop_sync} = {st, !st};
    @(negedge clk);
    {start_sync, hop_sync} = 2'b00;
    for (int c = 1; c < n; c++)
    begin
      chk(carrier_tuning_word, model_act);
      chk(32'(hold_count), 32'(n - c));
      @(negedge clk);
    end
    model_act = freq_wdata;
    chk(carrier_tuning_word, model_act);
  endtask : hop
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  initial
  begin
    void'($urandom(32'h8fd6ecd1));
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk(carrier_tuning_word, 32'h0);
    // second pass runs through the mixer at dc and zero phase, where the
    // unity-amplitude oscillator hands the samples on unchanged
    for (int k = 0; k < 32; k++)
    begin
      @(negedge clk);
      {osc_bypass, cplx_in, src_sel} = {k < 16, 4'(k)};
      @(posedge clk);
      #1;
      xbar(k % 16);
    end
    @(negedge clk);
    {osc_bypass, clr_acc_on_hop, phase_dither_en, amp_dither_en} = {1'b0, 3'($urandom)};
    {offset_wr, offset_wdata} = {1'b1, 16'($urandom)};
    @(negedge clk);
    offset_wr = 1'b0;
    hop(16'h0003, 1'b0);
    hop(16'h0001, 1'b1);
    hop(16'h0000, 1'b0);
    repeat (4) hop(16'($urandom_range(40, 2)), 1'($urandom));
    // clock enable low: a write and a sync are ignored and outputs stand
    @(negedge clk);
    {ce, freq_wr, hop_sync} = 3'b011;
    freq_wdata = ~model_act;
    held_i = out_i;
    repeat (3) @(negedge clk);
    chk(freq_shadow, model_act);
    chk(carrier_tuning_word, model_act);
    chk(32'(hold_busy), 32'h0);
    chk(32'(hold_count), 32'h0);
    chk(32'(out_i), 32'(held_i));
    {ce, freq_wr, hop_sync} = 3'b100;
    @(negedge clk);
    report_and_stop();
  end
endmodule : cnt_tuner_tb
`default_nettype wire
